// ===== sim/irqc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module irqc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_irq_take,
    input wire logic core_irq_req,
    input wire logic core_flush,
    input wire logic [15:0] core_vector
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_take_flush: assert property (core_irq_take && core_irq_req |=> core_flush)
        else $error("no flush after take");
    a_take_drop: assert property (core_irq_take && core_irq_req |=> !core_irq_req)
        else $error("request held after take");
    a_flush_cause: assert property (core_flush |-> $past(core_irq_take))
        else $error("flush without take");
    a_flush_once: assert property (core_flush |=> !core_flush)
        else $error("flush too long");
    a_vector_fixed: assert property (core_vector == 16'h0004)
        else $error("bad vector");
    a_ready_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bad ready timing");
    a_err_zero: assert property (pslverr |-> pready && prdata == '0)
        else $error("bad error read");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    cover property (core_flush);
    cover property (pslverr);
    cover property (core_irq_req && psel);
endmodule
bind irqc_top irqc_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_irq_take(core_irq_take), .core_irq_req(core_irq_req),
    .core_flush(core_flush), .core_vector(core_vector));
`default_nettype wire

// ===== sim/irqc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module irqc_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic [3:0] lat,
    input wire logic core_irq_req,
    input wire logic core_flush,
    output logic core_irq_take,
    output logic core_return
);
    logic [4:0] cnt;
    logic [4:0] hcnt;
    // a slow take stands for a core busy on a long instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
            core_irq_take <= 1'b0;
        end else begin
            core_irq_take <= en && core_irq_req && !core_irq_take && cnt == 5'(lat);
            cnt <= (en && core_irq_req && !core_irq_take) ? cnt + 5'd1 : '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt <= '0;
            core_return <= 1'b0;
        end else begin
            hcnt <= core_flush ? 5'd1 : hcnt + 5'(hcnt != 0);
            core_return <= hcnt == 5'd24;
        end
    end
endmodule
`default_nettype wire

// ===== sim/irqc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module irqc_top_tb;
    localparam logic [31:0] IMPL = 32'hC371_FF31;
    localparam logic [7:0] CT = irqc_pkg::ADDR_CTRL;
    localparam logic [7:0] EN0 = irqc_pkg::ADDR_EN0;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, core_en = 0;
    logic pready, pslverr, take, ret, req, flush;
    logic [7:0] paddr = 0, ext_pins = 0;
    logic [31:0] pwdata = 0, ev = 0, prdata;
    logic [3:0] lat = 0;
    logic [15:0] vec;
    int error_cnt = 0, compares = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    irqc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_pins(ext_pins), .evt_timer0_ovf(ev[5]),
        .lvl_pin_change(ev[4]), .evt_timer1_gate(ev[15]), .evt_converter_done(ev[14]),
        .lvl_uart_rx(ev[13]), .lvl_uart_tx(ev[12]), .evt_sync_serial(ev[11]),
        .evt_sync_serial_collision(ev[10]), .evt_timer2_match(ev[9]),
        .evt_timer1_ovf(ev[8]), .evt_comparator_b(ev[22]), .evt_comparator_a(ev[21]),
        .evt_nvm_done(ev[20]), .evt_osc_rollover(ev[16]), .evt_osc_fail(ev[31]),
        .evt_clock_switch_done(ev[30]), .evt_logic_cell_b(ev[25]),
        .evt_logic_cell_a(ev[24]), .core_irq_take(take), .core_return(ret),
        .core_irq_req(req), .core_flush(flush), .core_vector(vec));
    irqc_core_model core (.pclk(pclk), .presetn(presetn), .en(core_en), .lat(lat),
        .core_irq_req(req), .core_flush(flush), .core_irq_take(take), .core_return(ret));
    task automatic report_and_stop();
        if (error_cnt == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(string n, logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic xfer(logic wt, logic [7:0] a, logic [31:0] d, output logic [31:0] r,
            output logic e);
        psel <= 1'b1;
        pwrite <= wt;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, d, r, e);
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] x, logic xe);
        logic [31:0] r;
        logic e;
        xfer(1'b0, a, '0, r, e);
        chk("rdata", r, x);
        chk("slverr", 32'(e), 32'(xe));
    endtask
    task automatic s_mask();
        wr(CT, 32'hFFFF_FFFF);
        rdc(CT, 32'h0000_00C1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(EN0 + 8'(4 * i), 32'hFFFF_FFFF);
            rdc(EN0 + 8'(4 * i), 32'(IMPL[8*i+:8]), 1'b0);
            wr(EN0 + 8'(4 * i), '0);
        end
        wr(CT, 32'h0000_0001);
    endtask
    task automatic s_src(int b);
        logic [7:0] ea;
        logic [31:0] m;
        ea = EN0 + 8'(4 * (b / 8));
        m = 32'(1) << (b % 8);
        wr(ea, m);
        ev[b] <= 1'b1;
        w(1);
        // level sources stay up so their flag can be read
        ev[b] <= irqc_pkg::LEVEL_MASK[b];
        rdc(ea + 8'h10, m, 1'b0);
        chk("req", 32'(req), '0);
        wr(CT, 32'h0000_0081);
        w(3);
        chk("req", 32'(req), 32'(!irqc_pkg::PERIPH_MASK[b]));
        wr(CT, 32'h0000_00C1);
        w(3);
        chk("req", 32'(req), 32'h0000_0001);
        wr(ea, '0);
        w(3);
        chk("req", 32'(req), '0);
        ev[b] <= 1'b0;
        wr(ea + 8'h10, '0);
        wr(CT, 32'h0000_0001);
    endtask
    task automatic s_ext();
        wr(irqc_pkg::ADDR_REMAP, 32'h0000_0003);
        wr(EN0, 32'h0000_0001);
        wr(CT, 32'h0000_0081);
        ext_pins <= 8'h04;
        w(8);
        chk("req", 32'(req), '0);
        ext_pins <= 8'h0C;
        w(8);
        chk("req", 32'(req), 32'h0000_0001);
        wr(CT, 32'h0000_0080);
        wr(EN0 + 8'h10, '0);
        w(8);
        chk("req", 32'(req), '0);
        ext_pins <= 8'h00;
        w(8);
        chk("req", 32'(req), 32'h0000_0001);
        wr(EN0 + 8'h10, '0);
        wr(EN0, '0);
        wr(CT, 32'h0000_0001);
    endtask
    task automatic s_take(logic [3:0] l);
        lat <= l;
        wr(EN0 + 8'h04, 32'h0000_0001);
        wr(CT, 32'h0000_00C1);
        ev[8] <= 1'b1;
        core_en <= 1'b1;
        w(1);
        ev[8] <= 1'b0;
        for (int i = 0; i < 40 && flush !== 1'b1; i++)
            w(1);
        core_en <= 1'b0;
        wr(EN0 + 8'h14, '0);
        rdc(CT, 32'h0000_0041, 1'b0);
        w(30);
        rdc(CT, 32'h0000_00C1, 1'b0);
        wr(EN0 + 8'h04, '0);
        wr(CT, 32'h0000_0001);
    endtask
    initial begin
        w(12);
        presetn <= 1'b1;
        w(1);
        for (int a = 0; a <= 40; a += 4)
            rdc(8'(a), 32'(a == 0), a == 40);
        s_mask();
        for (int b = 1; b < 32; b++)
            if (IMPL[b])
                s_src(b);
        s_ext();
        s_take(4'd0);
        s_take(4'd9);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== src/irqc_pkg.sv
// Summary of operation
// - global enable, control bit 7, passes every enabled source not blocked by the peripheral enable; clear blocks all; resets 0
// - peripheral enable, control bit 6, passes peripheral sources; clear blocks them; resets 0
// - a peripheral source never requests while the peripheral enable is clear
// - edge select, control bit 0: 1 rising, 0 falling edge of pin; resets 1
// - control bits 5..1 and all unimplemented enable bits read as zero
// - enable 0 bit 5 gates timer-0 overflow; resets 0
// - enable 0 bit 4 gates pin change; resets 0
// - enable 0 bit 0 gates the external pin request; resets 0
// - the external pin comes through a remap select register, not a fixed pin
// - enable 1 bit 7 gates timer-1 gate, bit 6 converter done; reset 0
// - enable 1 bit 5 gates serial receive, bit 4 serial transmit; reset 0
// - enable 1 bit 3 gates sync serial, bit 2 its bus collision; reset 0
// - enable 1 bit 1 gates timer-2 match, bit 0 timer-1 overflow; reset 0
// - enable 2 bit 6 gates comparator b, bit 5 comparator a; reset 0
// - on the small variant comparator b is absent; its enable gates nothing
// - enable 2 bit 4 gates nonvolatile memory done; resets 0
// - enable 2 bit 0 gates oscillator rollover; resets 0
// - enable 3 bit 7 gates oscillator fail; resets 0
// - enable 3 bit 6 gates clock switch done; resets 0
// - enable 3 bit 1 gates logic cell b, bit 0 logic cell a; reset 0
// - each flag sets on its event regardless of any enable
// - taken request flushes prefetch, clears global enable, vectors to 0004h
// - return from handler sets the global enable again
// - external pin flag sets on each edge of the selected polarity
package irqc_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_EN0 = 8'h04;
    localparam logic [7:0] ADDR_EN3 = 8'h10;
    localparam logic [7:0] ADDR_FLAG0 = 8'h14;
    localparam logic [7:0] ADDR_FLAG3 = 8'h20;
    localparam logic [7:0] ADDR_REMAP = 8'h24;
    localparam int CTRL_GIE_BIT = 7;
    localparam int CTRL_PERIPH_IRQ_ENABLE_BIT = 6;
    localparam int CTRL_EDGE_BIT = 0;
    localparam logic CTRL_EDGE_RESET = 1'b1;
    // source bit positions in the 32-bit view {reg3, reg2, reg1, reg0}
    localparam int SRC_EXT_PIN = 0;
    localparam int SRC_PIN_CHANGE = 4;
    localparam int SRC_TIMER0_OVF = 5;
    localparam int SRC_TIMER1_OVF = 8;
    localparam int SRC_TIMER2_MATCH = 9;
    localparam int SRC_SYNC_COLL = 10;
    localparam int SRC_SYNC_SERIAL = 11;
    localparam int SRC_UART_TX = 12;
    localparam int SRC_UART_RX = 13;
    localparam int SRC_CONV_DONE = 14;
    localparam int SRC_TIMER1_GATE = 15;
    localparam int SRC_OSC_ROLL = 16;
    localparam int SRC_NVM_DONE = 20;
    localparam int SRC_COMP_A = 21;
    localparam int SRC_COMP_B = 22;
    localparam int SRC_LOGIC_A = 24;
    localparam int SRC_LOGIC_B = 25;
    localparam int SRC_CLK_SWITCH = 30;
    localparam int SRC_OSC_FAIL = 31;
    localparam logic [31:0] IMPL_MASK = 32'hC371_FF31;
    localparam logic [31:0] PERIPH_MASK = 32'hC371_FF00;
    localparam logic [31:0] LEVEL_MASK = 32'h0000_3010;
    localparam logic [31:0] EN_RESET = 32'h0000_0000;
    localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;
endpackage

// ===== src/irqc_top.sv
`timescale 1ns/100ps
`default_nettype none
module irqc_top #(
    parameter int EXT_PINS = 8,
    parameter int REMAP_W = 3,
    parameter bit HAS_COMPARATOR_B = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EXT_PINS-1:0] ext_pins,
    input wire logic evt_timer0_ovf,
    input wire logic lvl_pin_change,
    input wire logic evt_timer1_gate,
    input wire logic evt_converter_done,
    input wire logic lvl_uart_rx,
    input wire logic lvl_uart_tx,
    input wire logic evt_sync_serial,
    input wire logic evt_sync_serial_collision,
    input wire logic evt_timer2_match,
    input wire logic evt_timer1_ovf,
    input wire logic evt_comparator_b,
    input wire logic evt_comparator_a,
    input wire logic evt_nvm_done,
    input wire logic evt_osc_rollover,
    input wire logic evt_osc_fail,
    input wire logic evt_clock_switch_done,
    input wire logic evt_logic_cell_b,
    input wire logic evt_logic_cell_a,
    input wire logic core_irq_take,
    input wire logic core_return,
    output logic core_irq_req,
    output logic core_flush,
    output logic [15:0] core_vector
);
    logic global_irq_enable;
    logic periph_irq_enable;
    logic ext_pin_edge_select;
    logic [31:0] irq_en;
    logic [31:0] irq_flag;
    logic [REMAP_W-1:0] ext_pin_remap_select;
    logic [EXT_PINS-1:0] pin_meta;
    logic [EXT_PINS-1:0] pin_sync;
    logic pin_prev;
    logic pin_sel;
    logic ext_edge;
    logic [31:0] evt;
    logic [31:0] flag_view;
    logic [31:0] next_flag;
    logic [31:0] gated;
    logic setup;
    logic wr;
    logic mapped;
    logic [31:0] rd_val;
    logic [1:0] en_idx;
    logic [1:0] flag_idx;

    // two flops per pin before anything looks at it
    genvar gi;
    generate
        for (gi = 0; gi < EXT_PINS; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= ext_pins[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // selecting a new pin can look like an edge; clear the flag after remapping
    always_comb begin
        pin_sel = 1'b0;
        if (int'(ext_pin_remap_select) < EXT_PINS) begin
            pin_sel = pin_sync[ext_pin_remap_select];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= pin_sel;
        end
    end

    assign ext_edge = ext_pin_edge_select ? (pin_sel & ~pin_prev) : (~pin_sel & pin_prev);

    always_comb begin
        evt = 32'h0000_0000;
        evt[irqc_pkg::SRC_EXT_PIN] = ext_edge;
        evt[irqc_pkg::SRC_TIMER0_OVF] = evt_timer0_ovf;
        evt[irqc_pkg::SRC_TIMER1_GATE] = evt_timer1_gate;
        evt[irqc_pkg::SRC_CONV_DONE] = evt_converter_done;
        evt[irqc_pkg::SRC_SYNC_SERIAL] = evt_sync_serial;
        evt[irqc_pkg::SRC_SYNC_COLL] = evt_sync_serial_collision;
        evt[irqc_pkg::SRC_TIMER2_MATCH] = evt_timer2_match;
        evt[irqc_pkg::SRC_TIMER1_OVF] = evt_timer1_ovf;
        evt[irqc_pkg::SRC_COMP_B] = evt_comparator_b & HAS_COMPARATOR_B;
        evt[irqc_pkg::SRC_COMP_A] = evt_comparator_a;
        evt[irqc_pkg::SRC_NVM_DONE] = evt_nvm_done;
        evt[irqc_pkg::SRC_OSC_ROLL] = evt_osc_rollover;
        evt[irqc_pkg::SRC_OSC_FAIL] = evt_osc_fail;
        evt[irqc_pkg::SRC_CLK_SWITCH] = evt_clock_switch_done;
        evt[irqc_pkg::SRC_LOGIC_B] = evt_logic_cell_b;
        evt[irqc_pkg::SRC_LOGIC_A] = evt_logic_cell_a;
    end

    // level sources mirror their peripheral; software cannot clear them here
    always_comb begin
        flag_view = irq_flag;
        flag_view[irqc_pkg::SRC_PIN_CHANGE] = lvl_pin_change;
        flag_view[irqc_pkg::SRC_UART_RX] = lvl_uart_rx;
        flag_view[irqc_pkg::SRC_UART_TX] = lvl_uart_tx;
    end

    // byte index inside the 32-bit views; the flag block ends at 0x20, so bit 5 matters
    assign en_idx = 2'(paddr[5:2] - 4'd1);
    assign flag_idx = 2'(paddr[5:2] - 4'd5);
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready & pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        if (paddr == irqc_pkg::ADDR_CTRL) begin
            rd_val[irqc_pkg::CTRL_GIE_BIT] = global_irq_enable;
            rd_val[irqc_pkg::CTRL_PERIPH_IRQ_ENABLE_BIT] = periph_irq_enable;
            rd_val[irqc_pkg::CTRL_EDGE_BIT] = ext_pin_edge_select;
        end else if (paddr >= irqc_pkg::ADDR_EN0 && paddr <= irqc_pkg::ADDR_EN3 &&
                     paddr[1:0] == 2'b00) begin
            rd_val[7:0] = irq_en[8 * en_idx +: 8];
        end else if (paddr >= irqc_pkg::ADDR_FLAG0 && paddr <= irqc_pkg::ADDR_FLAG3 &&
                     paddr[1:0] == 2'b00) begin
            rd_val[7:0] = flag_view[8 * flag_idx +: 8];
        end else if (paddr == irqc_pkg::ADDR_REMAP) begin
            rd_val[REMAP_W-1:0] = ext_pin_remap_select;
        end else begin
            mapped = 1'b0;
        end
    end

    // one wait-free access phase: data and error latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= ~mapped;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_irq_enable <= 1'b0;
            ext_pin_edge_select <= irqc_pkg::CTRL_EDGE_RESET;
        end else if (wr && paddr == irqc_pkg::ADDR_CTRL) begin
            periph_irq_enable <= pwdata[irqc_pkg::CTRL_PERIPH_IRQ_ENABLE_BIT];
            ext_pin_edge_select <= pwdata[irqc_pkg::CTRL_EDGE_BIT];
        end
    end

    // hardware take and return override a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= 1'b0;
        end else if (core_irq_take && global_irq_enable) begin
            global_irq_enable <= 1'b0;
        end else if (core_return) begin
            global_irq_enable <= 1'b1;
        end else if (wr && paddr == irqc_pkg::ADDR_CTRL) begin
            global_irq_enable <= pwdata[irqc_pkg::CTRL_GIE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en <= irqc_pkg::EN_RESET;
        end else if (wr && paddr >= irqc_pkg::ADDR_EN0 && paddr <= irqc_pkg::ADDR_EN3 &&
                     paddr[1:0] == 2'b00) begin
            irq_en[8 * en_idx +: 8] <=
                pwdata[7:0] & irqc_pkg::IMPL_MASK[8 * en_idx +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_pin_remap_select <= '0;
        end else if (wr && paddr == irqc_pkg::ADDR_REMAP) begin
            ext_pin_remap_select <= pwdata[REMAP_W-1:0];
        end
    end

    // flags: software writes 0 to clear; an event in the same cycle wins
    always_comb begin
        next_flag = irq_flag;
        if (wr && paddr >= irqc_pkg::ADDR_FLAG0 && paddr <= irqc_pkg::ADDR_FLAG3 &&
            paddr[1:0] == 2'b00) begin
            next_flag[8 * flag_idx +: 8] = pwdata[7:0];
        end
        next_flag = (next_flag | evt) & irqc_pkg::IMPL_MASK & ~irqc_pkg::LEVEL_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag <= irqc_pkg::FLAG_RESET;
        end else begin
            irq_flag <= next_flag;
        end
    end

    assign gated = flag_view & irq_en & (irqc_pkg::PERIPH_MASK & {32{periph_irq_enable}} |
                                         ~irqc_pkg::PERIPH_MASK);

    // pc push and context save stay in the core; this block only vectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq_req <= 1'b0;
            core_flush <= 1'b0;
            core_vector <= irqc_pkg::IRQ_VECTOR;
        end else begin
            core_irq_req <= global_irq_enable & ~(core_irq_take & global_irq_enable) &
                            (|gated);
            core_flush <= core_irq_take & global_irq_enable;
            core_vector <= irqc_pkg::IRQ_VECTOR;
        end
    end
endmodule
`default_nettype wire
